// *** src/ssp_map.vh ***
/*
 * register offsets, field positions, reset values and timing counts
 * of the synchronous serial port. assumes nothing of its surroundings.
 */
`ifndef SSP_MAP_VH
`define SSP_MAP_VH

`define SSP_ADDR_CTRL 4'h0
`define SSP_ADDR_FIFO 4'h1
`define SSP_ADDR_IRQ 4'h2
`define SSP_ADDR_DIV 4'h3

`define SSP_CTRL_RESET 8'h80
`define SSP_BIT_ROLE 3
`define SSP_BIT_START 4
`define SSP_BIT_ICK 5
`define SSP_BIT_BUSY 6
`define SSP_BIT_ONE 7

`define SSP_IRQ_REQ 0
`define SSP_IRQ_EN 1
`define SSP_IRQ_PLO 2
`define SSP_IRQ_PHI 3

`define SSP_VECTOR 16'h003c
`define SSP_FIFO_DEPTH 32
`define SSP_INTERVAL_HALVES 4'h4

`endif

// *** src/ssp_clkdiv.v ***
/*
 * clock enable divider for master shift clock.
 * assumes a single system clock; sel chooses the half-period length.
 */
`timescale 1ns/1ps
`default_nettype none
module ssp_clkdiv (
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_run,
	input wire [2:0] i_sel,
	output reg o_tick
);
	reg [7:0] cnt_r;
	wire [7:0] limit;

	// half period of 2^sel system clocks
	assign limit = (8'h01 << i_sel) - 8'h01;

	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= 8'h00;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_r <= 8'h00;
			o_tick <= 1'b0;
		end else if (cnt_r >= limit) begin
			cnt_r <= 8'h00;
			o_tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 8'h01;
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** src/ssp_port.v ***
/*
 * synchronous serial port with 32-byte transmit and receive fifos,
 * master or slave role. assumes a plain register port on the system
 * clock; the serial clock pin is sampled, never used as a clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssp_map.vh"

module ssp_port #(
	parameter DEPTH = `SSP_FIFO_DEPTH
) (
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_sck,
	output reg o_sck,
	output wire o_sck_oe,
	output reg o_sdo,
	output wire o_sdo_oe,
	input wire i_sdi,
	output wire o_irq,
	output wire [1:0] o_irq_prio,
	output wire [15:0] o_irq_vector
);
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_SHIFT = 2'h2;
	localparam ST_DONE = 2'h3;

	reg [7:0] tx_mem [0:DEPTH-1];
	reg [7:0] rx_mem [0:DEPTH-1];
	reg [5:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	reg [6:0] ctrl_r;
	reg [3:0] irq_r;
	reg [1:0] st_r;
	reg [7:0] sh_tx_r, sh_rx_r;
	reg [2:0] bit_r;
	reg [5:0] left_r;
	reg [3:0] gap_r;
	reg [2:0] sck_sync_r, sdi_sync_r;
	reg sck_stable_r, sdi_stable_r;
	reg done_pend_r;
	reg [7:0] ctrl_rd;

	wire slave = ctrl_r[`SSP_BIT_ROLE];
	wire start = ctrl_r[`SSP_BIT_START];
	wire busy = (st_r != ST_IDLE);
	wire tick;
	wire m_rise, m_fall, s_rise, s_fall, rise, fall;
	// accepted pin level, usable in the cycle stages 2 and 3 agree
	wire sck_now = (sck_sync_r[1] == sck_sync_r[2]) ? sck_sync_r[2] : sck_stable_r;
	wire sdi_now = (sdi_sync_r[1] == sdi_sync_r[2]) ? sdi_sync_r[2] : sdi_stable_r;

	function sel;
		input [3:0] a;
		input [3:0] b;
		sel = (a == b);
	endfunction

	// master-only settings; slave ignores them
	ssp_clkdiv u_div (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_run(st_r == ST_SHIFT && !slave && gap_r == 4'h0),
		.i_sel(ctrl_r[2:0]),
		.o_tick(tick)
	);

	// three-stage pin sampling, change accepted when stages 2 and 3 agree
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sck_sync_r <= 3'h7;
			sdi_sync_r <= 3'h0;
			sck_stable_r <= 1'b1;
			sdi_stable_r <= 1'b0;
		end else begin
			sck_sync_r <= {sck_sync_r[1:0], i_sck};
			sdi_sync_r <= {sdi_sync_r[1:0], i_sdi};
			sck_stable_r <= sck_now;
			sdi_stable_r <= sdi_now;
		end
	end

	// edge seen one cycle early so slave data meets the partner's rising edge
	assign s_rise = slave && sck_now && !sck_stable_r;
	assign s_fall = slave && !sck_now && sck_stable_r;
	assign m_rise = !slave && tick && !o_sck;
	assign m_fall = !slave && tick && o_sck;
	assign rise = s_rise || m_rise;
	assign fall = s_fall || m_fall;

	always @* begin
		ctrl_rd = {1'b1, busy, ctrl_r[5:0]};
	end

	// register port
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
			rx_rp_r <= 6'h00;
		end else begin
			o_rdata <= 8'h00;
			if (i_rd) begin
				if (sel(i_addr, `SSP_ADDR_CTRL))
					o_rdata <= ctrl_rd;
				else if (sel(i_addr, `SSP_ADDR_FIFO)) begin
					o_rdata <= rx_mem[rx_rp_r[4:0]];
					if (rx_rp_r != rx_wp_r)
						rx_rp_r <= rx_rp_r + 6'h01;
				end else if (sel(i_addr, `SSP_ADDR_IRQ))
					o_rdata <= {4'h0, irq_r};
			end
			if (st_r == ST_LOAD)
				rx_rp_r <= 6'h00;
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_wr && sel(i_addr, `SSP_ADDR_FIFO) && !busy && tx_wp_r < DEPTH)
			tx_mem[tx_wp_r[4:0]] <= i_wdata;
		if (rise && bit_r == 3'h7 && st_r == ST_SHIFT)
			rx_mem[rx_wp_r[4:0]] <= {sdi_now, sh_rx_r[7:1]};
	end

	// transfer engine
	always @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= 7'h00;
			irq_r <= 4'h0;
			st_r <= ST_IDLE;
			tx_wp_r <= 6'h00;
			tx_rp_r <= 6'h00;
			rx_wp_r <= 6'h00;
			sh_tx_r <= 8'h00;
			sh_rx_r <= 8'h00;
			bit_r <= 3'h0;
			left_r <= 6'h00;
			gap_r <= 4'h0;
			o_sck <= 1'b1;
			o_sdo <= 1'b1;
			done_pend_r <= 1'b0;
		end else begin
			if (i_wr && sel(i_addr, `SSP_ADDR_CTRL))
				ctrl_r <= i_wdata[6:0] & 7'h3f;
			if (i_wr && sel(i_addr, `SSP_ADDR_IRQ))
				irq_r <= i_wdata[3:0];
			if (i_wr && sel(i_addr, `SSP_ADDR_FIFO) && !busy && tx_wp_r < DEPTH)
				tx_wp_r <= tx_wp_r + 6'h01;
			if (done_pend_r) begin
				irq_r[`SSP_IRQ_REQ] <= 1'b1; // set wins over clear
				done_pend_r <= 1'b0;
			end
			case (st_r)
			ST_IDLE: begin
				o_sck <= 1'b1;
				if (start && tx_wp_r != 6'h00)
					st_r <= ST_LOAD;
			end
			ST_LOAD: begin
				sh_tx_r <= tx_mem[0];
				o_sdo <= tx_mem[0][0];
				tx_rp_r <= 6'h01;
				rx_wp_r <= 6'h00;
				left_r <= tx_wp_r;
				bit_r <= 3'h0;
				gap_r <= 4'h0;
				st_r <= ST_SHIFT;
			end
			ST_SHIFT: begin
				if (gap_r != 4'h0)
					gap_r <= gap_r - 4'h1;
				if (m_rise || m_fall)
					o_sck <= ~o_sck;
				if (fall && bit_r != 3'h0)
					o_sdo <= sh_tx_r[bit_r];
				if (fall && bit_r == 3'h0 && left_r != tx_wp_r)
					o_sdo <= sh_tx_r[0];
				if (rise) begin
					sh_rx_r <= {sdi_now, sh_rx_r[7:1]};
					bit_r <= bit_r + 3'h1;
					if (bit_r == 3'h7) begin
						rx_wp_r <= rx_wp_r + 6'h01;
						left_r <= left_r - 6'h01;
						sh_tx_r <= tx_mem[tx_rp_r[4:0]];
						tx_rp_r <= tx_rp_r + 6'h01;
						if (!slave && ctrl_r[`SSP_BIT_ICK])
							gap_r <= `SSP_INTERVAL_HALVES;
						if (left_r == 6'h01)
							st_r <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (slave || o_sck) begin
					ctrl_r[`SSP_BIT_START] <= 1'b0;
					tx_wp_r <= 6'h00;
					done_pend_r <= 1'b1;
					st_r <= ST_IDLE;
				end else if (m_rise)
					o_sck <= 1'b1;
			end
			default: st_r <= ST_IDLE;
			endcase
			// abort when start cleared mid-transfer
			if (busy && st_r != ST_DONE && !start) begin
				st_r <= ST_IDLE;
				tx_wp_r <= 6'h00;
				o_sck <= 1'b1;
				o_sdo <= 1'b1;
			end
		end
	end

	assign o_sck_oe = !slave;
	assign o_sdo_oe = 1'b1;
	assign o_irq = irq_r[`SSP_IRQ_REQ] & irq_r[`SSP_IRQ_EN];
	assign o_irq_prio = {irq_r[`SSP_IRQ_PHI], irq_r[`SSP_IRQ_PLO]};
	assign o_irq_vector = `SSP_VECTOR;
endmodule
`default_nettype wire

// *** testbench/ssp_port_properties.sv ***
/* pin and register port properties of the serial port.
   sees only the top-level ports; bound below. */
`timescale 1ns/1ps
`default_nettype none
module ssp_port_properties (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_sck,
	input wire logic o_sck_oe,
	input wire logic o_sdo,
	input wire logic o_irq,
	input wire logic [1:0] o_irq_prio,
	input wire logic [15:0] o_irq_vector
);
	logic [7:0] wd_r;
	logic [7:0] low_r;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	always_ff @(posedge i_clk_sys) wd_r <= i_wdata;
	// master clock low time, longest half period is 128
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst)
			low_r <= 8'h00;
		else
			low_r <= (o_sck_oe && !o_sck) ? low_r + 8'h01 : 8'h00;
	end
	vector_fixed_a: assert property (
		o_irq_vector == 16'h003c) else $error("vector");
	prio_follow_a: assert property (
		i_wr && i_addr == 4'h2 |=> o_irq_prio == wd_r[3:2]) else $error("prio");
	irq_gate_a: assert property (
		i_wr && i_addr == 4'h2 && !i_wdata[1] |=> !o_irq) else $error("irq gate");
	role_pin_a: assert property (
		i_wr && i_addr == 4'h0 |=> o_sck_oe == !wd_r[3]) else $error("role");
	ctrl_top_a: assert property (
		i_rd && i_addr == 4'h0 |=> o_rdata[7]) else $error("bit 7");
	sdo_hold_a: assert property (
		o_sck_oe && $rose(o_sck) && !$past(i_wr, 2) |-> $stable(o_sdo)) else $error("sdo");
	idle_high_a: assert property (
		low_r <= 8'd130) else $error("sck low");
	abort_idle_a: assert property (
		i_wr && i_addr == 4'h0 && i_wdata[4:3] == 2'b00 |-> ##[1:4] o_sck)
		else $error("abort");
endmodule
bind ssp_port ssp_port_properties u_props (.i_clk_sys, .i_sys_rst, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .o_sck, .o_sck_oe, .o_sdo, .o_irq, .o_irq_prio, .o_irq_vector);
`default_nettype wire

// *** testbench/ssp_peer.sv ***
/* external serial device: shifts lsb first, answers 5a, 5b, ...
   drives its own clock only in bursts, for slave runs. */
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
	input wire logic i_sck,
	input wire logic i_sdo,
	output var logic o_sdi,
	output var logic o_sck
);
	logic [7:0] tx = 8'h5a;
	logic [7:0] rx = 8'h00;
	int n = 0;
	logic [7:0] q[$];
	initial o_sdi = 1'b0;
	initial o_sck = 1'b1;
	task automatic burst(input int bytes);
		// keep pin edges off the system clock edges
		#25;
		repeat (bytes * 8) begin
			#400 o_sck = 1'b0;
			#400 o_sck = 1'b1;
		end
	endtask
	always @(posedge i_sck) begin
		rx = {i_sdo, rx[7:1]};
		n++;
		if (n % 8 == 0) begin
			q.push_back(rx);
			tx++;
		end
	end
	always @(negedge i_sck) o_sdi = tx[n % 8];
endmodule
`default_nettype wire

// *** testbench/ssp_port_test.sv ***
/* self-checking bench for ssp_port.
   peer model on the pins; register port driven by tasks. */
`timescale 1ns/1ps
`default_nettype none
module ssp_port_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] a = 4'h0;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] r;
	logic [7:0] pin = 8'h5a;
	int fails = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 32'hb6f7;
	wire [7:0] rdat;
	wire sck_o, sck_oe, sdo, sdi, irq, psck;
	wire [1:0] prio;
	wire sck = sck_oe ? sck_o : psck;
	always #50 clk = ~clk;
	ssp_port i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdat), .i_sck(sck), .o_sck(sck_o), .o_sck_oe(sck_oe), .o_sdo(sdo),
		.o_sdo_oe(), .i_sdi(sdi), .o_irq(irq), .o_irq_prio(prio), .o_irq_vector());
	ssp_peer peer (.i_sck(sck), .i_sdo(sdo), .o_sdi(sdi), .o_sck(psck));
	task automatic put(input logic [3:0] ad, input logic [7:0] d);
		a <= ad;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic get(input logic [3:0] ad, output logic [7:0] d);
		a <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
		@(posedge clk);
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic xfer(input int n, input logic [7:0] c);
		logic [7:0] d;
		logic [7:0] sent[$];
		peer.n = 0;
		peer.q.delete();
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			if (i < 32) sent.push_back(d);
			put(4'h1, d);
		end
		put(4'h0, c);
		get(4'h0, d);
		chk("start", 8'h10, d & 8'h10);
		if (c[3]) peer.burst(sent.size());
		for (int k = 0; k < 5000 && d[4]; k++) get(4'h0, d);
		chk("busy", 8'h00, d & 8'h50);
		#1 chk("irq", 8'h01, {7'h0, irq});
		put(4'h2, 8'h02);
		foreach (sent[i]) begin
			get(4'h1, d);
			chk("rx", pin, d);
			pin++;
			chk("tx", sent[i], peer.q[i]);
		end
		$display("done n=%0d ctrl=%h", n, c);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			wrap_up;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		get(4'h0, r);
		chk("ctrl", 8'h80, r);
		get(4'h3, r);
		chk("unmapped", 8'h00, r);
		put(4'h2, 8'h0e);
		put(4'h2, 8'h00);
		put(4'h2, 8'h02);
		xfer(3, 8'h12);
		xfer(4, 8'h33);
		xfer(5, 8'h38);
		xfer(33, 8'h12);
		repeat (4) put(4'h1, 8'($random(seed)));
		put(4'h0, 8'h12);
		repeat (30) @(posedge clk);
		put(4'h0, 8'h02);
		get(4'h0, r);
		chk("abort", 8'h80, r & 8'hd0);
		chk("sck", 8'h01, {7'h0, sck});
		$display("done abort");
		wrap_up;
	end
endmodule
`default_nettype wire
